//--- common/igf_params.svh
// Behaviour
// - Sample blocking once at each cycle start.
// - Unblocked pick-up asserts start; forward pick-up runs operating timer.
// - Blocked pick-up flags blocked, no further processing.
// - Blocking during start releases like pick-up drop.
// - Forward hold timer retriggers, expiry clears forward flag.
// - Reverse hold timer retriggers, expiry clears reverse flag.
// - Operating timer runs while forward hold and start.
// - Forward release also zeroes operating timer.
// - Trip needs delay elapsed and spikes above threshold.
// - Too few spikes: no trip, release at hold expiry.
// - Definite delay trip ignores current magnitude.
// - Selectable on/off timestamped events, two single events.
// - Cumulative start, trip and blocked counters.
// - Rolling log of twelve most recent records.
// - Record holds timers, flags, counts, event, time, group.
// - Spikes remaining equals threshold minus forward count.
// - Condition reports normal, forward, reverse, trip, blocked.
// - Mode reports on, blocked, test, test-blocked, off.
// - Channel indication defaults to no voltage available.
// - Remaining trip time shown in 5 ms steps.
// - Expected operating time is readable.
// - Processing cycle is the 5 ms time base.
// - Start only unblocked and with detected spike.
`ifndef IGF_PARAMS_SVH
`define IGF_PARAMS_SVH
`define IGF_CLK_PERIOD_NS 10
`define IGF_CYCLE_MS      5
`define IGF_CYCLE_CLKS    (`IGF_CYCLE_MS * 1000000 / `IGF_CLK_PERIOD_NS)
`define IGF_BLOCK_LEAD_MS 5
`define IGF_FWD_HOLD_MS   300
`define IGF_REV_HOLD_MS   300
`define IGF_OP_DELAY_MS   500
`define IGF_TMR_W         20
`define IGF_FWD_HOLD_RST  20'(`IGF_FWD_HOLD_MS / `IGF_CYCLE_MS)
`define IGF_REV_HOLD_RST  20'(`IGF_REV_HOLD_MS / `IGF_CYCLE_MS)
`define IGF_OP_DELAY_RST  20'(`IGF_OP_DELAY_MS / `IGF_CYCLE_MS)
`define IGF_THR_RST       8'h02
`define IGF_CTRL_RST      7'h60
`define IGF_LOG_DEPTH     12
`define IGF_A_CTRL        8'h00
`define IGF_A_FWD_HOLD    8'h04
`define IGF_A_REV_HOLD    8'h08
`define IGF_A_OP_DELAY    8'h0C
`define IGF_A_THR         8'h10
`define IGF_A_STATUS      8'h14
`define IGF_A_REMAIN      8'h18
`define IGF_A_EXPECT      8'h1C
`define IGF_A_SPK_REMAIN  8'h20
`define IGF_A_CNT_START   8'h24
`define IGF_A_CNT_TRIP    8'h28
`define IGF_A_CNT_BLOCK   8'h2C
`define IGF_A_LOG_SEL     8'h30
`define IGF_A_LOG_TIME    8'h34
`define IGF_A_LOG_INFO    8'h38
`define IGF_A_LOG_REMAIN  8'h3C
`define IGF_A_LOG_SPIKES  8'h40
`define IGF_A_LOG_TOTRIP  8'h44
`endif

//--- common/igf_pkg.sv
package igf_pkg;
  typedef enum logic [2:0] {IGF_MODE_ON = 3'h0, IGF_MODE_BLOCKED = 3'h1, IGF_MODE_TEST = 3'h2,
                            IGF_MODE_TEST_BLK = 3'h3, IGF_MODE_OFF = 3'h4} igf_mode_t;
  typedef enum logic [2:0] {IGF_COND_NORMAL = 3'h0, IGF_COND_FWD = 3'h1, IGF_COND_REV = 3'h2,
                            IGF_COND_TRIP = 3'h3, IGF_COND_BLOCKED = 3'h4} igf_cond_t;
  typedef enum logic [1:0] {IGF_CHAN_NONE = 2'h0, IGF_CHAN_A = 2'h1, IGF_CHAN_B = 2'h2} igf_chan_t;
  typedef enum logic [3:0] {IGF_EV_FWD_ON = 4'h0, IGF_EV_FWD_OFF = 4'h1, IGF_EV_REV_ON = 4'h2,
                            IGF_EV_REV_OFF = 4'h3, IGF_EV_TRIP_ON = 4'h4, IGF_EV_TRIP_OFF = 4'h5,
                            IGF_EV_BLK_ON = 4'h6, IGF_EV_BLK_OFF = 4'h7, IGF_EV_DET_ON = 4'h8,
                            IGF_EV_DET_OFF = 4'h9, IGF_EV_NORMAL = 4'hA,
                            IGF_EV_LOCKED = 4'hB} igf_evt_t;
  typedef struct packed {
    logic      store_off;
    logic      store_on;
    igf_chan_t chan;
    igf_mode_t mode;
  } igf_ctrl_t;
  typedef struct packed {
    logic      blocked;
    logic      trip;
    logic      start;
    logic [3:0] log_count;
    igf_chan_t chan;
    igf_mode_t mode;
    igf_cond_t cond;
  } igf_status_t;
  typedef struct packed {
    logic [31:0] stamp;
    logic [2:0]  group;
    igf_evt_t    evt;
    logic        started_fwd;
    logic        started_rev;
    logic [19:0] remain;
    logic [15:0] spikes_fwd;
    logic [15:0] spikes_rev;
    logic [15:0] to_trip;
  } igf_rec_t;
  typedef struct packed {
    logic       sel;
    logic       write;
    logic [7:0] addr;
  } igf_bus_t;
endpackage

//--- src/igf_stage.sv
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "igf_params.svh"
module igf_stage #(
  parameter int unsigned CYCLE_CLKS = `IGF_CYCLE_CLKS
) (
  // Clock, reset and freeze
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Classified spikes, blocking matrix and active setting group
  input  wire logic        spike_fwd,
  input  wire logic        spike_rev,
  input  wire logic        block_in,
  input  wire logic [2:0]  setting_group,
  // Protection outputs
  output logic             start_out,
  output logic             trip_out,
  output logic             blocked_out,
  output logic             fwd_start_out,
  output logic             rev_start_out,
  output logic             fault_detected_out,
  // Event stream, one bit per event kind
  output logic             evt_valid,
  output logic [11:0]      evt_vec,
  output logic [31:0]      evt_time
);

  localparam int TW = $clog2(CYCLE_CLKS + 1);

  // ****************************************************************
  // Processing cycle time base
  // ****************************************************************
  logic [TW-1:0] tick_cnt_r;
  logic [31:0]   stamp_r;
  wire           tick = (tick_cnt_r == TW'(CYCLE_CLKS - 1));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt_r <= '0;
      stamp_r    <= 32'h0000_0000;
    end else if (ce) begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
      if (tick) begin
        stamp_r <= stamp_r + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // Bus front end and settings
  // ****************************************************************
  igf_pkg::igf_bus_t  bus_r;
  igf_pkg::igf_ctrl_t ctrl_r;
  logic [19:0] fwd_hold_r;
  logic [19:0] rev_hold_r;
  logic [19:0] op_delay_r;
  logic [7:0]  thr_r;
  logic [3:0]  log_sel_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  wire addr_phase = ce & hready & hsel & htrans[1];
  wire wr_en      = ce & bus_r.sel & bus_r.write;
  wire [7:0] wa   = bus_r.addr;
  wire clr_start  = wr_en & (wa == `IGF_A_CNT_START);
  wire clr_trip   = wr_en & (wa == `IGF_A_CNT_TRIP);
  wire clr_block  = wr_en & (wa == `IGF_A_CNT_BLOCK);

  // Always ready unless frozen, so a frozen block stalls the master
  // instead of dropping a write.
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_r   <= '0;
      rdata_r <= 32'h0000_0000;
    end else if (ce && hready) begin
      bus_r   <= '{sel: addr_phase, write: hwrite, addr: haddr[7:0]};
      rdata_r <= (addr_phase && !hwrite) ? rdata_nxt : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r     <= `IGF_CTRL_RST;
      fwd_hold_r <= `IGF_FWD_HOLD_RST;
      rev_hold_r <= `IGF_REV_HOLD_RST;
      op_delay_r <= `IGF_OP_DELAY_RST;
      thr_r      <= `IGF_THR_RST;
      log_sel_r  <= 4'h0;
    end else if (wr_en) begin
      if (wa == `IGF_A_CTRL) begin
        ctrl_r <= hwdata[6:0];
      end else if (wa == `IGF_A_FWD_HOLD) begin
        fwd_hold_r <= hwdata[19:0];
      end else if (wa == `IGF_A_REV_HOLD) begin
        rev_hold_r <= hwdata[19:0];
      end else if (wa == `IGF_A_OP_DELAY) begin
        op_delay_r <= hwdata[19:0];
      end else if (wa == `IGF_A_THR) begin
        thr_r <= hwdata[7:0];
      end else if (wa == `IGF_A_LOG_SEL) begin
        log_sel_r <= hwdata[3:0];
      end
    end
  end

  // ****************************************************************
  // Protection state
  // ****************************************************************
  logic        fwd_r, fwd_nxt, rev_r, rev_nxt;
  logic        trip_r, trip_nxt, blk_r, blk_nxt, det_r, det_nxt;
  logic [19:0] fwd_tmr_r, fwd_tmr_nxt, rev_tmr_r, rev_tmr_nxt;
  logic [19:0] op_r, op_nxt;
  logic [15:0] fcnt_r, fcnt_nxt, rcnt_r, rcnt_nxt;
  logic        normal_ev, locked_ev;

  igf_pkg::igf_mode_t mode;
  assign mode = ctrl_r.mode;
  wire running  = (mode != igf_pkg::IGF_MODE_OFF);
  wire blk_now  = block_in | (mode == igf_pkg::IGF_MODE_BLOCKED)
                | (mode == igf_pkg::IGF_MODE_TEST_BLK);
  wire pickup   = spike_fwd | spike_rev;
  wire started  = fwd_r | rev_r;

  always_comb begin
    fwd_nxt = fwd_r;  fwd_tmr_nxt = fwd_tmr_r;  fcnt_nxt = fcnt_r;
    rev_nxt = rev_r;  rev_tmr_nxt = rev_tmr_r;  rcnt_nxt = rcnt_r;
    op_nxt  = op_r;   trip_nxt = trip_r;  blk_nxt = blk_r;  det_nxt = det_r;
    normal_ev = 1'b0;
    locked_ev = 1'b0;
    // Blocking is looked at only on the cycle boundary, ahead of spikes.
    if (tick) begin
      if (!running) begin
        fwd_nxt = 1'b0;  fwd_tmr_nxt = '0;  fcnt_nxt = '0;
        rev_nxt = 1'b0;  rev_tmr_nxt = '0;  rcnt_nxt = '0;
        op_nxt  = '0;    trip_nxt = 1'b0;  blk_nxt = 1'b0;  det_nxt = 1'b0;
      end else if (blk_now) begin
        if (started) begin
          // Same release path as a dropped pick-up.
          fwd_nxt = 1'b0;  fwd_tmr_nxt = '0;  fcnt_nxt = '0;
          rev_nxt = 1'b0;  rev_tmr_nxt = '0;  rcnt_nxt = '0;
          op_nxt  = '0;    trip_nxt = 1'b0;   det_nxt = 1'b0;
          locked_ev = 1'b1;
        end else if (pickup) begin
          blk_nxt = 1'b1;
        end
      end else begin
        blk_nxt = 1'b0;
        if (spike_fwd) begin
          fwd_nxt     = 1'b1;
          fwd_tmr_nxt = fwd_hold_r;
          fcnt_nxt    = fcnt_r + 16'h0001;
        end else if (fwd_tmr_r > 20'h0_0001) begin
          fwd_tmr_nxt = fwd_tmr_r - 20'h0_0001;
        end else if (fwd_r) begin
          fwd_nxt = 1'b0;  fwd_tmr_nxt = '0;  fcnt_nxt = '0;
          op_nxt  = '0;    trip_nxt = 1'b0;   det_nxt = 1'b0;
        end
        if (spike_rev) begin
          rev_nxt     = 1'b1;
          rev_tmr_nxt = rev_hold_r;
          rcnt_nxt    = rcnt_r + 16'h0001;
        end else if (rev_tmr_r > 20'h0_0001) begin
          rev_tmr_nxt = rev_tmr_r - 20'h0_0001;
        end else if (rev_r) begin
          rev_nxt = 1'b0;  rev_tmr_nxt = '0;  rcnt_nxt = '0;
        end
        if (fwd_nxt && fwd_tmr_nxt != 20'h0_0000 && op_r < op_delay_r) begin
          op_nxt = op_r + 20'h0_0001;
        end
        // Definite time only: magnitude plays no part once spikes qualify.
        if (fwd_nxt && (op_nxt >= op_delay_r)) begin
          if (fcnt_nxt > {8'h00, thr_r}) begin
            trip_nxt = 1'b1;
            det_nxt  = 1'b1;
          end else if (op_r < op_delay_r) begin
            normal_ev = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fwd_r <= 1'b0;  fwd_tmr_r <= '0;  fcnt_r <= '0;
      rev_r <= 1'b0;  rev_tmr_r <= '0;  rcnt_r <= '0;
      op_r  <= '0;    trip_r <= 1'b0;  blk_r <= 1'b0;  det_r <= 1'b0;
    end else if (ce) begin
      fwd_r <= fwd_nxt;  fwd_tmr_r <= fwd_tmr_nxt;  fcnt_r <= fcnt_nxt;
      rev_r <= rev_nxt;  rev_tmr_r <= rev_tmr_nxt;  rcnt_r <= rcnt_nxt;
      op_r  <= op_nxt;   trip_r <= trip_nxt;  blk_r <= blk_nxt;  det_r <= det_nxt;
    end
  end

  // Test mode runs the timers but never drives the trip output.
  wire trip_live = trip_r & (mode != igf_pkg::IGF_MODE_TEST);
  assign start_out          = started;
  assign trip_out           = trip_live;
  assign blocked_out        = blk_r;
  assign fwd_start_out      = fwd_r;
  assign rev_start_out      = rev_r;
  assign fault_detected_out = det_r;

  // ****************************************************************
  // Live values
  // ****************************************************************
  wire [19:0] remain   = (fwd_r && op_r < op_delay_r) ? op_delay_r - op_r
                                                      : 20'h0_0000;
  wire [15:0] to_trip  = ({8'h00, thr_r} > fcnt_r) ? {8'h00, thr_r} - fcnt_r
                                                   : 16'h0000;

  igf_pkg::igf_cond_t cond;
  assign cond = blk_r  ? igf_pkg::IGF_COND_BLOCKED :
                trip_r ? igf_pkg::IGF_COND_TRIP    :
                fwd_r  ? igf_pkg::IGF_COND_FWD     :
                rev_r  ? igf_pkg::IGF_COND_REV     : igf_pkg::IGF_COND_NORMAL;

  // Unused channel codes fall back to the no-voltage indication.
  igf_pkg::igf_chan_t chan;
  assign chan = (ctrl_r.chan == igf_pkg::IGF_CHAN_A) ? igf_pkg::IGF_CHAN_A :
                (ctrl_r.chan == igf_pkg::IGF_CHAN_B) ? igf_pkg::IGF_CHAN_B :
                igf_pkg::IGF_CHAN_NONE;

  // ****************************************************************
  // Events and counters
  // ****************************************************************
  wire start_on = (fwd_nxt | rev_nxt) & ~started;
  wire trip_on  = trip_nxt & ~trip_r;
  wire blk_on   = blk_nxt & ~blk_r;
  wire [11:0] ev_raw = {locked_ev, normal_ev,
                        det_r & ~det_nxt,   det_nxt & ~det_r,
                        blk_r & ~blk_nxt,   blk_on,
                        trip_r & ~trip_nxt, trip_on,
                        rev_r & ~rev_nxt,   rev_nxt & ~rev_r,
                        fwd_r & ~fwd_nxt,   fwd_nxt & ~fwd_r};
  wire [11:0] ev_keep = {{2{ctrl_r.store_on}}, {5{ctrl_r.store_off, ctrl_r.store_on}}};
  wire [11:0] ev_sel  = ev_raw & ev_keep;

  logic [31:0] cnt_start_r, cnt_trip_r, cnt_blk_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      evt_valid <= 1'b0;
      evt_vec   <= 12'h000;
      evt_time  <= 32'h0000_0000;
    end else if (ce) begin
      evt_valid <= |ev_sel;
      evt_vec   <= ev_sel;
      evt_time  <= stamp_r;
    end
  end

  // A count event in the cycle of a software clear is kept as one.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_start_r <= 32'h0000_0000;
      cnt_trip_r  <= 32'h0000_0000;
      cnt_blk_r   <= 32'h0000_0000;
    end else if (ce) begin
      if (start_on) begin
        cnt_start_r <= clr_start ? 32'h0000_0001 : cnt_start_r + 32'h0000_0001;
      end else if (clr_start) begin
        cnt_start_r <= 32'h0000_0000;
      end
      if (trip_on) begin
        cnt_trip_r <= clr_trip ? 32'h0000_0001 : cnt_trip_r + 32'h0000_0001;
      end else if (clr_trip) begin
        cnt_trip_r <= 32'h0000_0000;
      end
      if (blk_on) begin
        cnt_blk_r <= clr_block ? 32'h0000_0001 : cnt_blk_r + 32'h0000_0001;
      end else if (clr_block) begin
        cnt_blk_r <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Fault record log
  // ****************************************************************
  igf_pkg::igf_rec_t log_mem [`IGF_LOG_DEPTH];
  igf_pkg::igf_rec_t rec_new;
  igf_pkg::igf_rec_t rec_rd;
  logic [3:0] wr_ptr_r;
  logic [3:0] log_cnt_r;
  igf_pkg::igf_evt_t rec_evt;

  wire capture = start_on | trip_on | blk_on;
  assign rec_evt = trip_on ? igf_pkg::IGF_EV_TRIP_ON :
                   blk_on  ? igf_pkg::IGF_EV_BLK_ON  :
                   (fwd_nxt & ~fwd_r) ? igf_pkg::IGF_EV_FWD_ON : igf_pkg::IGF_EV_REV_ON;
  assign rec_new = '{stamp: stamp_r, group: setting_group, evt: rec_evt,
                     started_fwd: fwd_nxt, started_rev: rev_nxt,
                     remain: (op_delay_r > op_nxt) ? op_delay_r - op_nxt : 20'h0_0000,
                     spikes_fwd: fcnt_nxt, spikes_rev: rcnt_nxt,
                     to_trip: ({8'h00, thr_r} > fcnt_nxt) ? {8'h00, thr_r} - fcnt_nxt
                                                          : 16'h0000};

  // Newest record is selector 0; selectors past the fill level read zero.
  wire [4:0] rd_sum = {1'b0, wr_ptr_r} + 5'(`IGF_LOG_DEPTH - 1) - {1'b0, log_sel_r};
  wire [4:0] rd_idx = (rd_sum >= 5'(`IGF_LOG_DEPTH)) ? rd_sum - 5'(`IGF_LOG_DEPTH) : rd_sum;
  assign rec_rd = (log_sel_r < log_cnt_r) ? log_mem[rd_idx[3:0]] : '0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_r  <= 4'h0;
      log_cnt_r <= 4'h0;
    end else if (ce && capture) begin
      wr_ptr_r  <= (wr_ptr_r == 4'(`IGF_LOG_DEPTH - 1)) ? 4'h0 : wr_ptr_r + 4'h1;
      if (log_cnt_r != 4'(`IGF_LOG_DEPTH)) begin
        log_cnt_r <= log_cnt_r + 4'h1;
      end
    end
  end

  // Record storage has no reset; the fill level hides stale entries.
  always_ff @(posedge sys_clk) begin
    if (ce && capture) begin
      log_mem[wr_ptr_r] <= rec_new;
    end
  end

  // ****************************************************************
  // Read decode
  // ****************************************************************
  igf_pkg::igf_status_t status;
  assign status = '{blocked: blk_r, trip: trip_live, start: started, log_count: log_cnt_r,
                    chan: chan, mode: mode, cond: cond};
  wire [7:0] ra = haddr[7:0];

  always_comb begin
    if (ra == `IGF_A_CTRL) begin
      rdata_nxt = {25'h0, ctrl_r};
    end else if (ra == `IGF_A_FWD_HOLD) begin
      rdata_nxt = {12'h000, fwd_hold_r};
    end else if (ra == `IGF_A_REV_HOLD) begin
      rdata_nxt = {12'h000, rev_hold_r};
    end else if (ra == `IGF_A_OP_DELAY) begin
      rdata_nxt = {12'h000, op_delay_r};
    end else if (ra == `IGF_A_THR) begin
      rdata_nxt = {24'h00_0000, thr_r};
    end else if (ra == `IGF_A_STATUS) begin
      rdata_nxt = {17'h0_0000, status};
    end else if (ra == `IGF_A_REMAIN) begin
      rdata_nxt = {12'h000, remain};
    end else if (ra == `IGF_A_EXPECT) begin
      rdata_nxt = {12'h000, op_delay_r};
    end else if (ra == `IGF_A_SPK_REMAIN) begin
      rdata_nxt = {16'h0000, to_trip};
    end else if (ra == `IGF_A_CNT_START) begin
      rdata_nxt = cnt_start_r;
    end else if (ra == `IGF_A_CNT_TRIP) begin
      rdata_nxt = cnt_trip_r;
    end else if (ra == `IGF_A_CNT_BLOCK) begin
      rdata_nxt = cnt_blk_r;
    end else if (ra == `IGF_A_LOG_SEL) begin
      rdata_nxt = {28'h000_0000, log_sel_r};
    end else if (ra == `IGF_A_LOG_TIME) begin
      rdata_nxt = rec_rd.stamp;
    end else if (ra == `IGF_A_LOG_INFO) begin
      rdata_nxt = {23'h00_0000, rec_rd.group, rec_rd.evt, rec_rd.started_rev,
                   rec_rd.started_fwd};
    end else if (ra == `IGF_A_LOG_REMAIN) begin
      rdata_nxt = {12'h000, rec_rd.remain};
    end else if (ra == `IGF_A_LOG_SPIKES) begin
      rdata_nxt = {rec_rd.spikes_rev, rec_rd.spikes_fwd};
    end else if (ra == `IGF_A_LOG_TOTRIP) begin
      rdata_nxt = {16'h0000, rec_rd.to_trip};
    end else begin
      rdata_nxt = 32'h0000_0000;
    end
  end

endmodule

//--- dv/igf_spike_src.sv
`timescale 1ns/1ps
// ****
// Spike detector and blocking matrix model
// ****
module igf_spike_src (
  // Clock and bench commands
  input  wire logic sys_clk,
  input  wire logic fwd_req,
  input  wire logic rev_req,
  input  wire logic blk_req,
  // Classified spikes and blocking level
  output logic      spike_fwd = 1'b0,
  output logic      spike_rev = 1'b0,
  output logic      block_in  = 1'b0
);
  // Levels move just after an edge, so a tick never sees a half-changed pick-up.
  always @(posedge sys_clk) begin
    spike_fwd <= fwd_req;
    spike_rev <= rev_req;
    block_in  <= blk_req;
  end
endmodule

//--- dv/igf_stage_props.sv
`timescale 1ns/1ps
module igf_stage_props #(
  parameter int unsigned CYCLE_CLKS = 20
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Detector inputs
  input wire logic        spike_fwd,
  input wire logic        spike_rev,
  input wire logic        block_in,
  // Protection outputs and event stream
  input wire logic        start_out,
  input wire logic        trip_out,
  input wire logic        blocked_out,
  input wire logic        fwd_start_out,
  input wire logic        rev_start_out,
  input wire logic        evt_valid,
  input wire logic [11:0] evt_vec,
  input wire logic [31:0] evt_time
);
  localparam int TICK_LIM = CYCLE_CLKS + 1;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence fwd_on_s; $rose(fwd_start_out); endsequence
  sequence fwd_on_evt_s; evt_valid && evt_vec[0]; endsequence
  start_join_a: assert property (start_out == (fwd_start_out | rev_start_out))
    else $error("start differs from flags");
  fwd_cause_a: assert property (fwd_on_s |-> $past(spike_fwd) && !$past(block_in))
    else $error("forward start without cause");
  rev_cause_a: assert property ($rose(rev_start_out) |-> $past(spike_rev))
    else $error("reverse start without spike");
  trip_fwd_a: assert property (trip_out |-> fwd_start_out)
    else $error("trip outlived forward start");
  blocked_cause_a: assert property ($rose(blocked_out) |-> $past(block_in))
    else $error("blocked without blocking");
  block_release_a: assert property (fwd_start_out && $rose(block_in) |->
    ##[1:TICK_LIM] !fwd_start_out) else $error("block did not release");
  fwd_event_a: assert property (fwd_on_s |-> fwd_on_evt_s)
    else $error("no forward on event");
  fwd_off_event_a: assert property ($fell(fwd_start_out) |-> evt_vec[1])
    else $error("no forward off event");
  trip_event_a: assert property ($rose(trip_out) |-> (evt_valid && evt_vec[4]))
    else $error("no trip on event");
  evt_time_step_a: assert property (evt_time == $past(evt_time)
    || evt_time == $past(evt_time) + 32'h0000_0001) else $error("event time jumped");
  evt_quiet_a: assert property (!evt_valid |-> evt_vec == 12'h000)
    else $error("event bits without valid");
endmodule
bind igf_stage igf_stage_props #(.CYCLE_CLKS(CYCLE_CLKS)) u_props (
  .sys_clk(sys_clk), .rst(rst), .spike_fwd(spike_fwd), .spike_rev(spike_rev),
  .block_in(block_in), .start_out(start_out), .trip_out(trip_out),
  .blocked_out(blocked_out), .fwd_start_out(fwd_start_out),
  .rev_start_out(rev_start_out), .evt_valid(evt_valid), .evt_vec(evt_vec),
  .evt_time(evt_time));

//--- dv/tb_top.sv
`timescale 1ns/1ps
`include "igf_params.svh"
module tb_top;
  localparam int CYC = 20;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        hsel    = 1'b1;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        fwd_req = 1'b0;
  logic        rev_req = 1'b0;
  logic        blk_req = 1'b0;
  logic        hreadyout, hresp, spike_fwd, spike_rev, block_in;
  logic        start_out, trip_out, blocked_out, fwd_start_out, rev_start_out, det;
  logic [31:0] hrdata, rd;
  int          fails   = 0;
  int          checked = 0;
  int          cyc     = 0;
  int          t0;
  wire  [3:0]  flags = {blocked_out, rev_start_out, trip_out, fwd_start_out};
  logic [7:0]  ra [7] = '{`IGF_A_CTRL, `IGF_A_FWD_HOLD, `IGF_A_OP_DELAY, `IGF_A_THR,
                          `IGF_A_EXPECT, `IGF_A_SPK_REMAIN, 8'h80};
  logic [31:0] rv [7] = '{32'h60, 32'h3C, 32'h64, 32'h2, 32'h64, 32'h2, 32'h0};

  igf_stage #(.CYCLE_CLKS(CYC)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .spike_fwd(spike_fwd),
    .spike_rev(spike_rev), .block_in(block_in), .setting_group(3'h5),
    .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
    .fwd_start_out(fwd_start_out), .rev_start_out(rev_start_out),
    .fault_detected_out(det), .evt_valid(), .evt_vec(), .evt_time());
  igf_spike_src u_src (
    .sys_clk(sys_clk), .fwd_req(fwd_req), .rev_req(rev_req), .blk_req(blk_req),
    .spike_fwd(spike_fwd), .spike_rev(spike_rev), .block_in(block_in));

  // ****
  // Clock, watchdog and bench tasks
  // ****
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // The whole run needs about 700 cycles; a stuck wait ends the run here.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_lvl(input int idx, input logic lvl);
    do @(posedge sys_clk); while (flags[idx] !== lvl);
  endtask
  task automatic finish_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****
  // Test sequence
  // ****
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (ra[i]) rchk(ra[i], rv[i]);
    for (int m = 0; m < 5; m++) begin
      bus(1'b1, `IGF_A_CTRL, 32'h60 | m | (m << 3));
      bus(1'b0, `IGF_A_STATUS, 32'h0);
      chk(rd[5:3], m[2:0]);
      chk(rd[7:6], (m % 4 == 3) ? 32'h0 : m % 4);
    end
    bus(1'b1, `IGF_A_CTRL, 32'h60);
    bus(1'b1, `IGF_A_FWD_HOLD, 32'h4);
    bus(1'b1, `IGF_A_REV_HOLD, 32'h3);
    bus(1'b1, `IGF_A_OP_DELAY, 32'h6);
    rchk(`IGF_A_EXPECT, 32'h6);
    // Steady forward spikes: trip five ticks after the start tick, release four after the last.
    fwd_req <= 1'b1;
    wait_lvl(0, 1'b1);
    chk(start_out, 32'h1);
    t0 = cyc;
    rchk(`IGF_A_REMAIN, 32'h5);
    wait_lvl(1, 1'b1);
    fwd_req <= 1'b0;
    chk(cyc - t0, 5 * CYC);
    chk(det, 32'h1);
    t0 = cyc;
    bus(1'b0, `IGF_A_STATUS, 32'h0);
    chk(rd[2:0], 32'h3);
    chk(rd[11:8], 32'h2);
    rchk(`IGF_A_SPK_REMAIN, 32'h0);
    wait_lvl(0, 1'b0);
    chk(cyc - t0, 4 * CYC);
    chk(trip_out, 32'h0);
    chk(det, 32'h0);
    rchk(`IGF_A_CNT_START, 32'h1);
    rchk(`IGF_A_CNT_TRIP, 32'h1);
    // Newest record is the trip, the one before it the start.
    rchk(`IGF_A_LOG_INFO, 32'h151);
    rchk(`IGF_A_LOG_SPIKES, 32'h6);
    bus(1'b1, `IGF_A_LOG_SEL, 32'h1);
    rchk(`IGF_A_LOG_REMAIN, 32'h5);
    rchk(`IGF_A_LOG_TOTRIP, 32'h1);
    // Delay elapses with too few spikes counted.
    bus(1'b1, `IGF_A_THR, 32'hA);
    fwd_req <= 1'b1;
    wait_lvl(0, 1'b1);
    repeat (130) @(posedge sys_clk);
    chk(trip_out, 32'h0);
    rchk(`IGF_A_SPK_REMAIN, 32'h3);
    fwd_req <= 1'b0;
    wait_lvl(0, 1'b0);
    rev_req <= 1'b1;
    wait_lvl(2, 1'b1);
    t0 = cyc;
    rev_req <= 1'b0;
    wait_lvl(2, 1'b0);
    chk(cyc - t0, 3 * CYC);
    // Blocking arrives after start, then pick-up persists while blocked.
    bus(1'b1, `IGF_A_THR, 32'h2);
    fwd_req <= 1'b1;
    wait_lvl(0, 1'b1);
    t0 = cyc;
    blk_req <= 1'b1;
    wait_lvl(0, 1'b0);
    chk(cyc - t0, CYC);
    wait_lvl(3, 1'b1);
    chk(fwd_start_out, 32'h0);
    bus(1'b0, `IGF_A_STATUS, 32'h0);
    chk(rd[2:0], 32'h4);
    blk_req <= 1'b0;
    fwd_req <= 1'b0;
    finish_test();
  end
endmodule
